// ### hdl/adx_decim_excite.sv
// Function
// RULE_01 - Decimation register at D4, reset 45
// RULE_02 - Rate is reference over 24x or 8x word
// RULE_03 - Chop disable bit zero means chopping on
// RULE_04 - Chopping treats words below 13 as 13
// RULE_05 - Calibration keeps the programmed decimation word
// RULE_06 - Software should program 255 before calibration
// RULE_07 - Excitation register at D5, reset 00
// RULE_08 - Burnout only on primary pairs five-six, seven-eight
// RULE_09 - Bit 3 routes source two: eight or seven
// RULE_10 - Bit 2 routes source one: seven or eight
// RULE_11 - Bits 1, 0 enable sources two, one
// RULE_12 - Bits 7, 5, 4 unimplemented, writes ignored
// RULE_13 - Excitation write immediate, converters not restarted
// RULE_14 - Discard outputs until third or fourth after change
// RULE_15 - Both sources may share one pin
// RULE_16 - Decimation readback returns the written value
`timescale 1ns/1ps
module adx_decim_excite
  import adx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [7:0] sfrAddr,              // Special function address
  input  wire logic [7:0] sfrWrData,            // Write data
  input  wire logic       sfrWr,                // Write strobe, one cycle
  input  wire logic       sfrRd,                // Read strobe, one cycle
  output logic      [7:0] sfrRdData,            // Read data, valid cycle after strobe
  input  wire logic       chopDisable,          // Chop disable bit of mode register
  input  wire logic [3:0] primaryChSel,         // Primary converter channel code
  input  wire logic       refClk,               // 32.768 kHz reference, sampled
  output logic            rateTick,             // One pulse per conversion output
  output logic      [7:0] decimationWord,       // Word the filter really uses
  output logic            sourceOneToSeven,     // First source drives input seven
  output logic            sourceOneToEight,     // First source drives input eight
  output logic            sourceTwoToSeven,     // Second source drives input seven
  output logic            sourceTwoToEight,     // Second source drives input eight
  output logic            burnoutPairFiveSix,   // Burnout on pair five-six
  output logic            burnoutPairSevenEight,// Burnout on pair seven-eight
  output logic            resultSettled         // Enough outputs since excitation change
);
  logic [7:0] sincDecimationCtrl;         // Decimation register
  logic [7:0] next_sincDecimationCtrl;
  logic [7:0] excitationCurrentCtrl;      // Excitation register, implemented bits only
  logic [7:0] next_excitationCurrentCtrl;
  logic [7:0] next_sfrRdData;
  logic       refPrev;                    // Reference level one cycle ago
  logic       refEdge;                    // Reference rising edge
  logic [2:0] settleCount;                // Outputs seen since last excitation change
  logic [2:0] next_settleCount;
  logic [2:0] settleTarget;               // Outputs needed for settling
  logic [4:0] rateMult;                   // 24 or 8
  logic [ADX_PERIOD_W-1:0] periodLen;     // Reference periods per output
  logic       decWrite;                   // Write hits decimation register
  logic       excWrite;                   // Write hits excitation register
  logic       excChange;                  // Excitation write alters a live bit

  assign decWrite  = sfrWr && (sfrAddr == ADX_DEC_ADDR);  // [RULE_01]
  assign excWrite  = sfrWr && (sfrAddr == ADX_EXC_ADDR);  // [RULE_07]
  assign excChange = excWrite &&
                     ((sfrWrData & ADX_EXC_IMPL_MASK) != excitationCurrentCtrl);

  // Register writes; unimplemented excitation bits dropped on the way in
  always_comb begin
    next_sincDecimationCtrl    = sincDecimationCtrl;
    next_excitationCurrentCtrl = excitationCurrentCtrl;
    if (decWrite) begin
      next_sincDecimationCtrl = sfrWrData;  // [RULE_01]
    end
    if (excWrite) begin
      next_excitationCurrentCtrl = sfrWrData & ADX_EXC_IMPL_MASK;  // [RULE_12]
    end
  end

  // Readback; raw word returned even when the filter clamps it
  always_comb begin
    next_sfrRdData = sfrRdData;
    if (sfrRd) begin
      case (sfrAddr)
        ADX_DEC_ADDR: next_sfrRdData = sincDecimationCtrl;     // [RULE_16]
        ADX_EXC_ADDR: next_sfrRdData = excitationCurrentCtrl;  // [RULE_12]
        default:      next_sfrRdData = 8'h00;  // Unmapped reads as zero
      endcase
    end
  end

  // Register state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sincDecimationCtrl    <= ADX_DEC_RESET;  // [RULE_01]
      excitationCurrentCtrl <= ADX_EXC_RESET;  // [RULE_07]
      sfrRdData             <= 8'h00;
    end else begin
      sincDecimationCtrl    <= next_sincDecimationCtrl;
      excitationCurrentCtrl <= next_excitationCurrentCtrl;
      sfrRdData             <= next_sfrRdData;
    end
  end

  // Effective word: clamp under chop; no calibration override exists here
  always_comb begin
    decimationWord = sincDecimationCtrl;  // [RULE_05]
    if (!chopDisable && (sincDecimationCtrl < ADX_CHOP_MIN)) begin  // [RULE_03]
      decimationWord = ADX_CHOP_MIN;  // [RULE_04]
    end
  end

  // Divisor choice by chop mode
  assign rateMult  = chopDisable ? ADX_NOCHOP_MULT : ADX_CHOP_MULT;  // [RULE_03]
  // Both factors widened first so the product cannot wrap (24 x 255 fits)
  assign periodLen = ADX_PERIOD_W'(rateMult) * ADX_PERIOD_W'(decimationWord);  // [RULE_02]

  // Reference edge detect; reference is taken as synchronous
  always_ff @(posedge clock) begin
    if (!rstn) begin
      refPrev <= 1'b0;
    end else begin
      refPrev <= refClk;
    end
  end
  assign refEdge = refClk && !refPrev;

  // Output rate generator; excitation writes never touch it
  adx_rate_divider #(
    .PERIOD_W (ADX_PERIOD_W)
  ) u_divider (
    .clock     (clock),
    .rstn      (rstn),
    .refEdge   (refEdge),
    .periodLen (periodLen),   // [RULE_02]
    .rateTick  (rateTick)     // [RULE_13]
  );

  // Excitation routing straight from the register, takes effect at once
  assign sourceOneToSeven = excitationCurrentCtrl[ADX_SRC1_EN_BIT] &&
                            !excitationCurrentCtrl[ADX_SRC1_SEL_BIT];  // [RULE_10] [RULE_11]
  assign sourceOneToEight = excitationCurrentCtrl[ADX_SRC1_EN_BIT] &&
                            excitationCurrentCtrl[ADX_SRC1_SEL_BIT];   // [RULE_10]
  assign sourceTwoToEight = excitationCurrentCtrl[ADX_SRC2_EN_BIT] &&
                            !excitationCurrentCtrl[ADX_SRC2_SEL_BIT];  // [RULE_09] [RULE_11]
  assign sourceTwoToSeven = excitationCurrentCtrl[ADX_SRC2_EN_BIT] &&
                            excitationCurrentCtrl[ADX_SRC2_SEL_BIT];   // [RULE_09]
  // Both sources may land on one pin; no exclusion is applied [RULE_15]

  // Burnout reaches only the two primary pairs, never the auxiliary path
  assign burnoutPairFiveSix    = excitationCurrentCtrl[ADX_BURNOUT_BIT] &&
                                 (primaryChSel == ADX_PAIR_FIVE_SIX);     // [RULE_08]
  assign burnoutPairSevenEight = excitationCurrentCtrl[ADX_BURNOUT_BIT] &&
                                 (primaryChSel == ADX_PAIR_SEVEN_EIGHT);  // [RULE_08]

  // Settling tracker helps software skip unsettled outputs
  assign settleTarget = chopDisable ? ADX_SETTLE_NOCHOP : ADX_SETTLE_CHOP;
  always_comb begin
    next_settleCount = settleCount;
    if (excChange) begin
      next_settleCount = 3'h0;  // Change restarts the wait [RULE_14]
    end else if (rateTick && (settleCount < settleTarget)) begin
      next_settleCount = settleCount + 3'h1;
    end
  end

  // Settle count; reset counts as settled since nothing changed yet
  always_ff @(posedge clock) begin
    if (!rstn) begin
      settleCount <= ADX_SETTLE_CHOP;
    end else begin
      settleCount <= next_settleCount;
    end
  end
  assign resultSettled = (settleCount >= settleTarget);  // [RULE_14]

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_dec_reset;
    disable iff (1'b0) !rstn |=> sincDecimationCtrl == ADX_DEC_RESET;
  endproperty
  a_dec_reset: assert property (p_dec_reset) else $error("bad decimation reset"); // [RULE_01]

  property p_exc_reset;
    disable iff (1'b0) !rstn |=> excitationCurrentCtrl == ADX_EXC_RESET;
  endproperty
  a_exc_reset: assert property (p_exc_reset) else $error("bad excitation reset"); // [RULE_07]

  property p_exc_mask;
    excWrite |=> excitationCurrentCtrl == ($past(sfrWrData) & ADX_EXC_IMPL_MASK);
  endproperty
  a_exc_mask: assert property (p_exc_mask) else $error("excitation write wrong"); // [RULE_12]

  property p_dec_readback;
    sfrRd && sfrAddr == ADX_DEC_ADDR && !decWrite |=> sfrRdData == sincDecimationCtrl;
  endproperty
  a_dec_readback: assert property (p_dec_readback) else $error("readback wrong"); // [RULE_16]

  property p_chop_clamp;
    !chopDisable |-> decimationWord >= ADX_CHOP_MIN;
  endproperty
  a_chop_clamp: assert property (p_chop_clamp) else $error("word below minimum"); // [RULE_04]

  property p_period;
    periodLen == (chopDisable ? 13'(decimationWord) * 13'h08 : 13'(decimationWord) * 13'h18);
  endproperty
  a_period: assert property (p_period) else $error("period divisor wrong"); // [RULE_02]

  property p_route;
    (sourceOneToSeven != sourceOneToEight || !excitationCurrentCtrl[0]) &&
    (sourceTwoToSeven == (excitationCurrentCtrl[1] && excitationCurrentCtrl[3]));
  endproperty
  a_route: assert property (p_route) else $error("routing wrong"); // [RULE_09]

  property p_burnout;
    (burnoutPairFiveSix || burnoutPairSevenEight) |-> excitationCurrentCtrl[6];
  endproperty
  a_burnout: assert property (p_burnout) else $error("burnout without enable"); // [RULE_08]

  property p_settle;
    excChange |=> !resultSettled;
  endproperty
  a_settle: assert property (p_settle) else $error("settled too early"); // [RULE_14]

  property p_exc_no_restart;
    excWrite && !decWrite |=> decimationWord == $past(decimationWord) || $changed(chopDisable);
  endproperty
  a_exc_no_restart: assert property (p_exc_no_restart) else $error("rate disturbed"); // [RULE_13]

  c_tick: cover property (rateTick);
  c_clamp: cover property (!chopDisable && sincDecimationCtrl < ADX_CHOP_MIN);
  c_share: cover property (sourceOneToEight && sourceTwoToEight);
  c_settle: cover property (excChange ##[1:1000] resultSettled);
endmodule : adx_decim_excite

// ### hdl/adx_pkg.sv
package adx_pkg;
  // Register map of the special function space
  localparam logic [7:0] ADX_DEC_ADDR      = 8'hD4;  // Decimation register address
  localparam logic [7:0] ADX_DEC_RESET     = 8'h45;  // Decimation power-on value
  localparam logic [7:0] ADX_EXC_ADDR      = 8'hD5;  // Excitation register address
  localparam logic [7:0] ADX_EXC_RESET     = 8'h00;  // Excitation power-on value
  localparam logic [7:0] ADX_EXC_IMPL_MASK = 8'h4F;  // Bits 7, 5, 4 not implemented

  // Excitation field positions
  localparam int ADX_SRC1_EN_BIT  = 0;  // First source enable
  localparam int ADX_SRC2_EN_BIT  = 1;  // Second source enable
  localparam int ADX_SRC1_SEL_BIT = 2;  // First source: 0 input seven, 1 input eight
  localparam int ADX_SRC2_SEL_BIT = 3;  // Second source: 0 input eight, 1 input seven
  localparam int ADX_BURNOUT_BIT  = 6;  // Burnout current enable

  // Rate divisors in reference clock periods per decimation step
  localparam logic [4:0] ADX_CHOP_MULT   = 5'h18;  // 3 x 8 with chopping
  localparam logic [4:0] ADX_NOCHOP_MULT = 5'h08;  // 8 without chopping
  localparam logic [7:0] ADX_CHOP_MIN    = 8'h0D;  // Least word while chopping

  // Outputs to discard after an excitation change
  localparam logic [2:0] ADX_SETTLE_CHOP   = 3'h4;  // Fourth output settled, chop on
  localparam logic [2:0] ADX_SETTLE_NOCHOP = 3'h3;  // Third output settled, chop off

  // Primary channel codes of the two burnout-capable input pairs
  localparam logic [3:0] ADX_PAIR_FIVE_SIX    = 4'hC;
  localparam logic [3:0] ADX_PAIR_SEVEN_EIGHT = 4'hD;

  // Period counter width: 24 x 255 needs 13 bits
  localparam int ADX_PERIOD_W = 13;
endpackage : adx_pkg

// ### hdl/adx_rate_divider.sv
`timescale 1ns/1ps
// Counts reference clock edges and pulses once per conversion period
module adx_rate_divider
  import adx_pkg::*;
#(
  parameter int PERIOD_W = ADX_PERIOD_W  // Width of the period count
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                refEdge,    // One pulse per reference period
  input  wire logic [PERIOD_W-1:0] periodLen,  // Reference periods per output
  output logic                     rateTick    // One pulse per conversion output
);
  logic [PERIOD_W-1:0] refCount;       // Edges counted in this period
  logic [PERIOD_W-1:0] next_refCount;  // Next edge count
  logic                wrapNow;        // Period completes on this edge

  // A shortened period takes effect at once via the >= compare
  assign wrapNow  = refEdge && (refCount >= periodLen - PERIOD_W'(1));
  assign rateTick = wrapNow;

  // Next count
  always_comb begin
    next_refCount = refCount;
    if (wrapNow) begin
      next_refCount = '0;
    end else if (refEdge) begin
      next_refCount = refCount + PERIOD_W'(1);
    end
  end

  // Count register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      refCount <= '0;
    end else begin
      refCount <= next_refCount;
    end
  end
endmodule : adx_rate_divider

// ### test/adx_decim_excite_tb.sv
`timescale 1ns/1ps
// One compare: counts it, reports a mismatch at once
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
  end \
end
module adx_decim_excite_tb;
  import adx_pkg::*;
  logic       clock;         // 125 MHz system clock
  logic       rstn;          // Synchronous reset, active low
  logic [7:0] sfrAddr;       // Register address
  logic [7:0] sfrWrData;     // Write data
  logic       sfrWr;         // Write strobe
  logic       sfrRd;         // Read strobe
  logic [7:0] sfrRdData;     // Read data
  logic       chopDisable;   // Chop mode select
  logic [3:0] primaryChSel;  // Primary channel code
  logic [1:0] refDiv;        // Reference divider
  logic       refClk;        // Reference, one rising edge per 4 clocks
  logic       rateTick;      // Conversion output pulse
  logic [7:0] decimationWord;
  logic [3:0] route;         // One-seven, one-eight, two-seven, two-eight
  logic [1:0] burnout;       // Pair five-six, pair seven-eight
  logic       resultSettled;
  int         n_errors;      // Mismatch count
  int         n_checks;      // Compare count
  int         gapLen;        // Clocks between output pulses

  adx_decim_excite uut (
    .clock(clock), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .chopDisable(chopDisable),
    .primaryChSel(primaryChSel), .refClk(refClk), .rateTick(rateTick),
    .decimationWord(decimationWord), .sourceOneToSeven(route[3]),
    .sourceOneToEight(route[2]), .sourceTwoToSeven(route[1]), .sourceTwoToEight(route[0]),
    .burnoutPairFiveSix(burnout[1]), .burnoutPairSevenEight(burnout[0]),
    .resultSettled(resultSettled)
  );

  // Clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Reference runs free, stepped just after each edge
  always @(posedge clock) begin
    #1;
    refDiv <= refDiv + 2'h1;
  end
  assign refClk = refDiv[1];

  // Register write; strobe held across exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 sfrWr = 1'b1;
    sfrAddr = a;
    sfrWrData = d;
    @(posedge clock);
    #1 sfrWr = 1'b0;
    @(negedge clock);
  endtask : wr

  // Register read; data is registered on the taking edge and checked at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 sfrRd = 1'b1;
    sfrAddr = a;
    @(posedge clock);
    #1 sfrRd = 1'b0;
    @(negedge clock);
    `CHK("read data", e, sfrRdData)
  endtask : rd

  // Clocks to the next output pulse, bounded so a dead divider fails
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rateTick !== 1'b1 && n < 5000);
  endtask : gap

  // Verdict, reached by the tests or by the watchdog
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Watchdog well beyond the longest expected run
  initial begin
    #400000;
    n_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    rstn = 1'b0;
    refDiv = 2'h0;
    {sfrWr, sfrRd, chopDisable} = 3'b000;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    primaryChSel = 4'h0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    @(negedge clock);
    `CHK("outputs after reset", 7'h01, {route, burnout, resultSettled})
    `CHK("word after reset", ADX_DEC_RESET, decimationWord)
    rd(ADX_DEC_ADDR, 8'h45);
    rd(ADX_EXC_ADDR, 8'h00);
    $display("test reset done");

    // Every enable and routing code, shared pin included
    for (int v = 0; v < 16; v++) begin
      wr(ADX_EXC_ADDR, 8'(v));
      `CHK("routing", {v[0] & ~v[2], v[0] & v[2], v[1] & v[3], v[1] & ~v[3]}, route)
    end
    wr(ADX_EXC_ADDR, 8'hFF);
    rd(ADX_EXC_ADDR, 8'h4F);
    $display("test routing done");

    // Burnout only on the two primary pairs, only with its bit set
    for (int b = 0; b < 2; b++) begin
      wr(ADX_EXC_ADDR, b ? 8'h40 : 8'h00);
      for (int c = 0; c < 3; c++) begin
        @(posedge clock);
        #1 primaryChSel = (c == 0) ? 4'hC : (c == 1) ? 4'hD : 4'h7;
        @(negedge clock);
        `CHK("burnout", {b[0] && c == 0, b[0] && c == 1}, burnout)
      end
    end
    $display("test burnout done");

    // Unmapped address: write dropped, read gives zero, mapped ones untouched
    wr(8'hD6, 8'hFF);
    rd(8'hD6, 8'h00);
    rd(ADX_DEC_ADDR, 8'h45);
    rd(ADX_EXC_ADDR, 8'h40);
    $display("test unmapped done");

    // Small word: clamped while chopping, readback unchanged
    wr(ADX_DEC_ADDR, 8'h05);
    `CHK("clamped word", 8'h0D, decimationWord)
    rd(ADX_DEC_ADDR, 8'h05);
    gap(gapLen);
    gap(gapLen);
    `CHK("chop period", 24 * 13 * 4, gapLen)
    @(posedge clock);
    #1 chopDisable = 1'b1;
    @(negedge clock);
    `CHK("unclamped word", 8'h05, decimationWord)
    wr(ADX_DEC_ADDR, 8'h03);
    gap(gapLen);
    gap(gapLen);
    `CHK("plain period", 8 * 3 * 4, gapLen)
    $display("test rate done");

    // Excitation change mid period: no restart, settling over three outputs
    wr(ADX_EXC_ADDR, 8'h01);
    `CHK("settled drops", 1'b0, resultSettled)
    gap(gapLen);
    `CHK("period across write", 8 * 3 * 4, gapLen + 2)
    gap(gapLen);
    `CHK("not settled yet", 1'b0, resultSettled)
    gap(gapLen);
    @(negedge clock);
    `CHK("settled", 1'b1, resultSettled)
    $display("test settle done");

    // Largest word stays in use, as for a calibration
    @(posedge clock);
    #1 chopDisable = 1'b0;
    wr(ADX_DEC_ADDR, 8'hFF);
    `CHK("largest word", 8'hFF, decimationWord)
    rd(ADX_DEC_ADDR, 8'hFF);
    $display("test largest word done");

    // Reset in mid-run restores both power-on values
    @(posedge clock);
    #1 rstn = 1'b0;
    @(posedge clock);
    #1 rstn = 1'b1;
    @(negedge clock);
    `CHK("outputs after second reset", 7'h01, {route, burnout, resultSettled})
    `CHK("word after second reset", ADX_DEC_RESET, decimationWord)
    rd(ADX_DEC_ADDR, ADX_DEC_RESET);
    rd(ADX_EXC_ADDR, ADX_EXC_RESET);
    $display("test second reset done");
    conclude();
  end
endmodule : adx_decim_excite_tb
